//--- logic/pm_clock_cfg.svh
`ifndef PM_CLOCK_CFG_SVH
`define PM_CLOCK_CFG_SVH

// Register byte addresses (printed offsets are not all multiples of four, so index*4)
`define IDX_EXT_IRQ_FLAGS 8'h91
`define IDX_POWER_MGMT_CTRL 8'hc4
`define IDX_ACTIVITY_STATUS 8'hc5
`define ADDR_EXT_IRQ_FLAGS 12'h244
`define ADDR_POWER_MGMT_CTRL 12'h310
`define ADDR_ACTIVITY_STATUS 12'h314
// Own register for serial transmit-buffer write events
`define ADDR_TX_BUFFER_WRITE 12'h400

// Field positions
`define POS_DIV_HI 7
`define POS_DIV_LO 6
`define POS_AUTO_RET 5
`define POS_XTAL_OFF 3
`define POS_SRC_SEL 3
`define POS_RING_ACT 2
`define POS_PF_LVL 7
`define POS_HI_LVL 6
`define POS_LO_LVL 5
`define POS_XTAL_RDY 4

// Divider codes
`define DIV_CODE_RSVD 2'b00
`define DIV_CODE_4 2'b01
`define DIV_CODE_64 2'b10
`define DIV_CODE_1024 2'b11

// Clocks per machine cycle
`define CLKS_4 11'h004
`define CLKS_64 11'h040
`define CLKS_1024 11'h400

// Crystal warm-up in crystal clocks
`define XTAL_WARMUP_CLKS 65536

`endif

//--- logic/pm_clock_pkg.sv
package pm_clock_pkg;
    // Divider selection
    typedef enum logic [1:0] {
        DIV_RSVD,
        DIV_4,
        DIV_64,
        DIV_1024
    } div_sel_e;

    // Serial port activity seen from the ports
    typedef struct packed {
        logic port1_tx_active;
        logic port1_rx_active;
        logic port0_tx_active;
        logic port0_rx_active;
    } serial_act_s;

    // Interrupt levels in service
    typedef struct packed {
        logic powerfail_level_active;
        logic high_level_active;
        logic low_level_active;
    } level_act_s;
endpackage

//--- logic/cycle_divider.sv
`timescale 1ns/1ps
`include "pm_clock_cfg.svh"

// Counts source-clock ticks into machine-cycle strobes
module cycle_divider
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Source tick and length
    input wire logic src_tick,
    input wire logic [10:0] cycle_len,
    // One-cycle strobe at machine-cycle end
    output logic cycle_end
);
    logic [10:0] count; // Ticks inside the current cycle

    // Strobe when the last tick of the cycle arrives
    assign cycle_end = src_tick && (count >= cycle_len - 11'h001);

    // A shortened length ends an overlong cycle at the next source tick, never wraps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= 11'h000;
        else if (cycle_end)
            count <= 11'h000;
        else if (src_tick)
            count <= count + 11'h001;
    end
endmodule

//--- logic/power_mgmt_clock_divider.sv
// Function
// RQ1: Reset and normal: four clocks per cycle
// RQ2: Two-bit code selects 4, 64, 1024
// RQ3: New rate applies after one cycle
// RQ4: Divided strobe feeds all clocked functions
// RQ5: Reduced rates reachable only from 4-clock
// RQ6: Only software enters reduced speed
// RQ7: Valid external interrupt forces 4-clock
// RQ8: Start bit with receiver on forces 4-clock
// RQ9: Start bit raises no serial interrupt
// RQ10: Transmit buffer write forces 4-clock
// RQ11: Auto return only while enable set
// RQ12: Only takeable interrupts trigger return
// RQ13: Low level in service blocks low sources
// RQ14: Status bits 7..5 show levels in service
// RQ15: Status bits 0,1 show port 0 activity
// RQ16: Status bits 2,3 show port 1 activity
// RQ17: Software avoids rate change during transfers
// RQ18: Ring oscillator usable as clock source
// RQ19: Software restores rate then crystal
// RQ20: Source select bit; ring status bit
// RQ21: Crystal disable only while ring selected
// RQ22: Crystal ready after warm-up; gates crystal select
// RQ23: Auto return leaves clock source alone
// RQ24: Illegal divider writes are ignored
// RQ25: Auto return loads 4-clock code
`timescale 1ns/1ps
`include "pm_clock_cfg.svh"

module power_mgmt_clock_divider
#(
    parameter int WARMUP_CLKS = `XTAL_WARMUP_CLKS
)
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock source ticks (pins, synchronised here)
    input wire logic xtal_tick,
    input wire logic ring_tick,
    // Interrupt logic
    input wire logic [5:0] ext_irq_pending,
    input wire logic [5:0] ext_irq_enabled,
    input wire logic [5:0] ext_irq_high_prio,
    input wire pm_clock_pkg::level_act_s level_act,
    // Serial ports
    input wire logic [1:0] start_bit_seen,
    input wire logic [1:0] rx_enable,
    input wire pm_clock_pkg::serial_act_s serial_act,
    // Divided machine-cycle strobe and state
    output logic machine_cycle,
    output logic crystal_off,
    output logic ring_active_flag,
    output pm_clock_pkg::div_sel_e active_div
);
    import pm_clock_pkg::*;

    // Warm-up counter is 17 bits wide; a longer warm-up would be cut to its low 17 bits and end early
    if (WARMUP_CLKS < 1 || WARMUP_CLKS > 32'h0002_0000)
    begin : gen_bad_warmup
        $error("WARMUP_CLKS out of range");
    end

    // Pin synchronisers: first stage read only by the second
    logic xt_s1, xt_s2, xt_s3, rg_s1, rg_s2, rg_s3;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xt_s1 <= 1'b0;
            xt_s2 <= 1'b0;
            xt_s3 <= 1'b0;
            rg_s1 <= 1'b0;
            rg_s2 <= 1'b0;
            rg_s3 <= 1'b0;
        end
        else
        begin
            xt_s1 <= xtal_tick;
            xt_s2 <= xt_s1;
            xt_s3 <= xt_s2;
            rg_s1 <= ring_tick;
            rg_s2 <= rg_s1;
            rg_s3 <= rg_s2;
        end
    end
    wire xt_edge = xt_s2 && !xt_s3; // One pclk per crystal clock
    wire rg_edge = rg_s2 && !rg_s3; // One pclk per ring clock

    // Control state
    logic [1:0] div_code; // Software-visible divider field
    div_sel_e applied_div; // Rate actually in use
    logic auto_return; // Switchback enable
    logic xtal_disable; // Crystal amplifier off
    logic src_select; // 1 crystal, 0 ring
    logic ring_mode; // Source actually running
    logic xtal_ready; // Warm-up done
    logic [16:0] warm_count; // Crystal clocks since re-enable
    logic pend_apply; // Rate change waits one cycle
    logic pend_src; // Source change waits one cycle
    logic [7:0] pmr_low; // Other bits of the control register kept as storage

    // APB decode
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire hit_pmr = (paddr == `ADDR_POWER_MGMT_CTRL);
    wire hit_ext_irq_flags = (paddr == `ADDR_EXT_IRQ_FLAGS);
    wire hit_stat = (paddr == `ADDR_ACTIVITY_STATUS);
    wire hit_txb = (paddr == `ADDR_TX_BUFFER_WRITE);
    wire mapped = hit_pmr || hit_ext_irq_flags || hit_stat || hit_txb;
    wire wr_pmr = wr && hit_pmr;
    wire wr_ext_irq_flags = wr && hit_ext_irq_flags;
    wire [1:0] wr_code = pwdata[`POS_DIV_HI:`POS_DIV_LO];

    // Reduced rate only from 4-clock; reserved code dropped [RQ5] [RQ24]
    wire code_legal = (wr_code == `DIV_CODE_4) ||
        ((wr_code != `DIV_CODE_RSVD) && (div_code == `DIV_CODE_4));
    // Transmit buffer write event for either port, pwdata[0]=port0 [1]=port1 [RQ10]
    wire tx_write = wr && hit_txb && (pwdata[1:0] != 2'b00);

    // External interrupt that could be taken now [RQ7] [RQ12] [RQ13]
    logic [5:0] irq_takeable;
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : gen_irq
            assign irq_takeable[g] = ext_irq_pending[g] && ext_irq_enabled[g] &&
                !level_act.powerfail_level_active && !level_act.high_level_active &&
                (ext_irq_high_prio[g] || !level_act.low_level_active);
        end
    endgenerate
    // Start bit only with its receiver on; raises no interrupt here [RQ8] [RQ9]
    wire start_hit = |(start_bit_seen & rx_enable);
    // Hardware can only restore speed, never reduce it [RQ6] [RQ11]
    wire switchback = auto_return && ((|irq_takeable) || start_hit || tx_write);

    // Source tick and length of the applied rate [RQ18]
    wire src_tick = ring_mode ? rg_edge : xt_edge;
    wire [10:0] cycle_len = (applied_div == DIV_1024) ? `CLKS_1024 :
        (applied_div == DIV_64) ? `CLKS_64 : `CLKS_4;
    wire cyc_end;

    // Divider counter for the whole device [RQ4]
    cycle_divider u_div
    (
        .pclk(pclk),
        .presetn(presetn),
        .src_tick(src_tick),
        .cycle_len(cycle_len),
        .cycle_end(cyc_end)
    );

    // Divider field: software writes, hardware switchback [RQ2] [RQ25]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_code <= `DIV_CODE_4; // [RQ1]
        else if (switchback)
            div_code <= `DIV_CODE_4; // Return wins over a write
        else if (wr_pmr && code_legal)
            div_code <= wr_code;
    end

    // Applied rate follows after one machine cycle; switchback immediate [RQ3]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            applied_div <= DIV_4;
            pend_apply <= 1'b0;
        end
        else if (switchback)
        begin
            applied_div <= DIV_4;
            pend_apply <= 1'b0;
        end
        else if (wr_pmr && code_legal)
            pend_apply <= 1'b1;
        else if (pend_apply && cyc_end)
        begin
            applied_div <= div_sel_e'(div_code);
            pend_apply <= 1'b0;
        end
    end

    // Other control bits; switchback leaves source untouched [RQ23]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            auto_return <= 1'b0;
            xtal_disable <= 1'b0;
            pmr_low <= 8'h00;
        end
        else if (wr_pmr)
        begin
            auto_return <= pwdata[`POS_AUTO_RET];
            // Setting allowed only with ring selected [RQ21]
            xtal_disable <= pwdata[`POS_XTAL_OFF] && (!src_select || xtal_disable);
            pmr_low <= {4'h0, pwdata[4], pwdata[2:0]};
            if (src_select && !xtal_disable)
                xtal_disable <= 1'b0;
        end
    end

    // Source select; crystal only once ready [RQ20] [RQ22]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_select <= 1'b1;
            pend_src <= 1'b0;
            ring_mode <= 1'b0;
        end
        else
        begin
            if (wr_ext_irq_flags && (!pwdata[`POS_SRC_SEL] || (xtal_ready && !xtal_disable)))
            begin
                src_select <= pwdata[`POS_SRC_SEL];
                pend_src <= 1'b1;
            end
            else if (pend_src && cyc_end)
            begin
                ring_mode <= !src_select;
                pend_src <= 1'b0;
            end
        end
    end

    // Crystal warm-up count in crystal clocks [RQ22]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            warm_count <= 17'h00000;
            xtal_ready <= 1'b1;
        end
        else if (xtal_disable)
        begin
            warm_count <= 17'h00000;
            xtal_ready <= 1'b0;
        end
        else if (!xtal_ready && xt_edge)
        begin
            warm_count <= warm_count + 17'h00001;
            if (warm_count == 17'(WARMUP_CLKS - 1))
                xtal_ready <= 1'b1;
        end
    end

    // Read data selection [RQ14] [RQ15] [RQ16]
    wire [7:0] pmr_rd = {div_code, auto_return, pmr_low[4], xtal_disable, pmr_low[2:0]};
    wire [7:0] ext_irq_flags_rd = {4'h0, src_select, ring_mode, 2'b00};
    wire [7:0] stat_rd = {level_act.powerfail_level_active, level_act.high_level_active,
        level_act.low_level_active, xtal_ready, serial_act};
    wire [7:0] rd_byte = hit_pmr ? pmr_rd : hit_ext_irq_flags ? ext_irq_flags_rd : hit_stat ? stat_rd : 8'h00;

    // APB answer: one access cycle, error for unmapped addresses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    // Registered outputs to the rest of the device [RQ4]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            machine_cycle <= 1'b0;
            crystal_off <= 1'b0;
            ring_active_flag <= 1'b0;
            active_div <= DIV_4;
        end
        else
        begin
            machine_cycle <= cyc_end;
            crystal_off <= xtal_disable;
            ring_active_flag <= ring_mode;
            active_div <= applied_div;
        end
    end

    // Assertions
    AST_RESET_FOUR: assert property (@(posedge pclk) $rose(presetn) |-> applied_div == DIV_4) // [RQ1]
        else $error("rate not 4 after reset");
    AST_SWB_RESTORE: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
        switchback |=> (applied_div == DIV_4 && div_code == `DIV_CODE_4))
        else $error("switchback did not restore 4 clocks");
    AST_NO_DIRECT: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
        (div_code == `DIV_CODE_64) |=> div_code != `DIV_CODE_1024)
        else $error("direct reduced rate change");
    AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn) // [RQ24]
        div_code != `DIV_CODE_RSVD)
        else $error("reserved code stored");
    AST_HW_NO_SLOW: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
        (!wr_pmr && !pend_apply && applied_div == DIV_4) |=> applied_div == DIV_4)
        else $error("hardware reduced speed");
    AST_SWB_GATED: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
        !auto_return |-> !switchback)
        else $error("switchback while disabled");
    AST_LEVEL_LOCK: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
        level_act.high_level_active |-> irq_takeable == 6'h00)
        else $error("blocked interrupt took effect");
    AST_SRC_KEEP: assert property (@(posedge pclk) disable iff (!presetn) // [RQ23]
        (switchback && !wr_ext_irq_flags) |=> $stable(src_select))
        else $error("switchback changed source");
    AST_XTAL_GATE: assert property (@(posedge pclk) disable iff (!presetn) // [RQ22]
        $rose(src_select) |-> $past(xtal_ready))
        else $error("crystal selected before ready");
    // A pending rate must wait for the end of the running machine cycle
    AST_RATE_WAIT: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
        (pend_apply && !cyc_end && !switchback) |=> $stable(applied_div))
        else $error("rate changed before cycle end");
    AST_START_RETURN: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
        (auto_return && start_hit) |=> applied_div == DIV_4)
        else $error("start bit did not restore 4 clocks");

    // Main scenarios
    COV_SWB: cover property (@(posedge pclk) disable iff (!presetn) switchback && applied_div == DIV_1024);
    COV_DIV64_MODE: cover property (@(posedge pclk) disable iff (!presetn) $rose(applied_div == DIV_64));
    COV_RING: cover property (@(posedge pclk) disable iff (!presetn) $rose(ring_mode));
    COV_TX_RETURN: cover property (@(posedge pclk) disable iff (!presetn) auto_return && tx_write);
    COV_XTAL_UP: cover property (@(posedge pclk) disable iff (!presetn) $rose(xtal_ready));
endmodule

//--- test/clock_partner.sv
`timescale 1ns/1ps

// Far side: oscillators feeding the block and a timer consuming its strobe
module clock_partner
#(
    parameter int XTAL_HALF = 3,
    parameter int RING_HALF = 4
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // From the block
    input wire logic crystal_off,
    input wire logic machine_cycle,
    // Source ticks
    output logic xtal_tick,
    output logic ring_tick,
    // Clocks between the last two strobes
    output logic [15:0] period
);
    logic [3:0] xcnt; // Crystal half-period count
    logic [3:0] rcnt; // Ring half-period count
    logic [15:0] cnt; // Clocks since last strobe

    // Crystal stands still while disabled, as a stopped amplifier would
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn || crystal_off)
        begin
            xcnt <= 4'h0;
            xtal_tick <= 1'b0;
        end
        else if (xcnt == 4'(XTAL_HALF - 1))
        begin
            xcnt <= 4'h0;
            xtal_tick <= ~xtal_tick;
        end
        else
            xcnt <= xcnt + 4'h1;
    end

    // Ring runs whenever out of reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rcnt <= 4'h0;
            ring_tick <= 1'b0;
        end
        else if (rcnt == 4'(RING_HALF - 1))
        begin
            rcnt <= 4'h0;
            ring_tick <= ~ring_tick;
        end
        else
            rcnt <= rcnt + 4'h1;
    end

    // Timer view of the strobe: spacing of machine cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 16'h0;
            period <= 16'h0;
        end
        else if (machine_cycle)
        begin
            period <= cnt;
            cnt <= 16'h1;
        end
        else
            cnt <= cnt + 16'h1;
    end
endmodule

//--- test/power_mgmt_clock_divider_tb_top.sv
`timescale 1ns/1ps
`include "pm_clock_cfg.svh"

module power_mgmt_clock_divider_tb_top;
    import pm_clock_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic xtal_tick, ring_tick, machine_cycle, crystal_off, ring_active_flag;
    logic [5:0] pend, en, hp; // External sources
    level_act_s lvl;
    logic [1:0] sbit, rxe; // Start bits, receiver enables
    serial_act_s sact;
    div_sel_e active_div;
    logic [15:0] period;
    int failures, compares;
    logic [33:0] cases [9]; // ctrl, pend, en, hp, lvl, sbit, rxe, returns

    power_mgmt_clock_divider #(.WARMUP_CLKS(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xtal_tick(xtal_tick), .ring_tick(ring_tick),
        .ext_irq_pending(pend), .ext_irq_enabled(en), .ext_irq_high_prio(hp), .level_act(lvl),
        .start_bit_seen(sbit), .rx_enable(rxe), .serial_act(sact), .machine_cycle(machine_cycle),
        .crystal_off(crystal_off), .ring_active_flag(ring_active_flag), .active_div(active_div));

    clock_partner far (.pclk(pclk), .presetn(presetn), .crystal_off(crystal_off),
        .machine_cycle(machine_cycle), .xtal_tick(xtal_tick), .ring_tick(ring_tick), .period(period));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic finish_test();
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // A wait that ran out ends the run
    task automatic tmo(input string nm);
        failures++;
        $display("Error %s expected done seen timeout", nm);
        finish_test();
    endtask

    // One APB transfer; request held until pready seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
            tmo("pready");
        // Answer taken at the edge that saw pready, then the request is released
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, x, r);
    endtask

    function automatic logic [31:0] watch(input int s);
        return (s == 0) ? 32'(active_div) : 32'((s == 1) ? ring_active_flag : crystal_off);
    endfunction

    // Bounded wait for an output to reach a value
    task automatic wait_for(input int s, input logic [31:0] x, input string nm);
        int n;
        for (n = 0; n < 8000 && watch(s) !== x; n++)
            @(posedge pclk);
        if (n == 8000)
            tmo(nm);
        chk(nm, x, watch(s));
    endtask

    // Spacing of machine-cycle strobes, after the rate has settled
    task automatic per(input logic [15:0] x);
        int n;
        repeat (3)
        begin
            for (n = 0; n < 8000 && machine_cycle !== 1'b1; n++)
                @(posedge pclk);
            if (n == 8000)
                tmo("machine_cycle");
            @(posedge pclk);
        end
        chk("period", 32'(x), 32'(period));
    endtask

    // Judge a return case, then clear triggers and go back to full speed
    task automatic settle(input div_sel_e x, input logic [7:0] c);
        repeat (20) @(posedge pclk);
        chk("active_div", 32'(x), 32'(active_div));
        rd(`ADDR_POWER_MGMT_CTRL, {24'h0, c}, "ctrl");
        {pend, en, hp, lvl, sbit, rxe} <= '0;
        wr(`ADDR_POWER_MGMT_CTRL, 32'h40);
        wait_for(0, 32'(DIV_4), "active_div");
    endtask

    initial
    begin
        logic [31:0] r;
        logic e;
        int n;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pend, en, hp, lvl, sbit, rxe, sact} = '0;
        failures = 0;
        compares = 0;
        presetn = 1'b0;
        cases = '{{8'h80, 6'h01, 6'h01, 6'h00, 3'b000, 2'b00, 2'b00, 1'b0},
                  {8'ha0, 6'h01, 6'h00, 6'h00, 3'b000, 2'b00, 2'b00, 1'b0},
                  {8'ha0, 6'h01, 6'h01, 6'h00, 3'b000, 2'b00, 2'b00, 1'b1},
                  {8'ha0, 6'h01, 6'h01, 6'h00, 3'b010, 2'b00, 2'b00, 1'b0},
                  {8'ha0, 6'h01, 6'h01, 6'h00, 3'b001, 2'b00, 2'b00, 1'b0},
                  {8'ha0, 6'h02, 6'h02, 6'h02, 3'b001, 2'b00, 2'b00, 1'b1},
                  {8'ha0, 6'h02, 6'h02, 6'h02, 3'b100, 2'b00, 2'b00, 1'b0},
                  {8'ha0, 6'h00, 6'h00, 6'h00, 3'b000, 2'b01, 2'b00, 1'b0},
                  {8'ha0, 6'h00, 6'h00, 6'h00, 3'b000, 2'b10, 2'b10, 1'b1}};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("active_div", 32'(DIV_4), 32'(active_div));
        rd(`ADDR_POWER_MGMT_CTRL, 32'h40, "ctrl");
        rd(`ADDR_ACTIVITY_STATUS, 32'h10, "status");
        rd(`ADDR_EXT_IRQ_FLAGS, 32'h08, "ext_flags");
        per(16'd24);
        wr(`ADDR_POWER_MGMT_CTRL, 32'h00);
        rd(`ADDR_POWER_MGMT_CTRL, 32'h40, "ctrl");
        rd(`ADDR_ACTIVITY_STATUS, 32'h10, "status");
        wr(`ADDR_POWER_MGMT_CTRL, 32'h80);
        wait_for(0, 32'(DIV_64), "active_div");
        per(16'd384);
        wr(`ADDR_POWER_MGMT_CTRL, 32'hc0);
        wr(`ADDR_POWER_MGMT_CTRL, 32'h00);
        rd(`ADDR_POWER_MGMT_CTRL, 32'h80, "ctrl");
        wr(`ADDR_POWER_MGMT_CTRL, 32'h40);
        wait_for(0, 32'(DIV_4), "active_div");
        wr(`ADDR_POWER_MGMT_CTRL, 32'hc0);
        wait_for(0, 32'(DIV_1024), "active_div");
        per(16'd6144);
        wr(`ADDR_POWER_MGMT_CTRL, 32'h80);
        rd(`ADDR_POWER_MGMT_CTRL, 32'hc0, "ctrl");
        wr(`ADDR_POWER_MGMT_CTRL, 32'h40);
        wait_for(0, 32'(DIV_4), "active_div");
        // Hardware return sources, each from the 64-clock rate
        foreach (cases[i])
        begin
            wr(`ADDR_POWER_MGMT_CTRL, {24'h0, cases[i][33:26]});
            wait_for(0, 32'(DIV_64), "active_div");
            {pend, en, hp, lvl, sbit, rxe} <= cases[i][25:1];
            settle(cases[i][0] ? DIV_4 : DIV_64, cases[i][0] ? {2'b01, cases[i][31:26]} : cases[i][33:26]);
        end
        for (int p = 1; p < 3; p++)
        begin
            wr(`ADDR_POWER_MGMT_CTRL, 32'ha0);
            wait_for(0, 32'(DIV_64), "active_div");
            wr(`ADDR_TX_BUFFER_WRITE, 32'(p));
            settle(DIV_4, 8'h60);
        end
        lvl <= 3'b101;
        sact <= 4'b1010;
        @(posedge pclk);
        rd(`ADDR_ACTIVITY_STATUS, 32'hba, "status");
        lvl <= 3'b010;
        sact <= 4'b0101;
        @(posedge pclk);
        rd(`ADDR_ACTIVITY_STATUS, 32'h55, "status");
        lvl <= 3'b000;
        sact <= 4'b0000;
        apb(1'b0, 12'h0f0, 32'h0, r, e);
        chk("pslverr", 32'h1, 32'(e));
        // Ring operation and crystal restart
        wr(`ADDR_POWER_MGMT_CTRL, 32'h48);
        chk("crystal_off", 32'h0, 32'(crystal_off));
        rd(`ADDR_POWER_MGMT_CTRL, 32'h40, "ctrl");
        wr(`ADDR_EXT_IRQ_FLAGS, 32'h00);
        wait_for(1, 32'h1, "ring_active_flag");
        rd(`ADDR_EXT_IRQ_FLAGS, 32'h04, "ext_flags");
        per(16'd32);
        wr(`ADDR_POWER_MGMT_CTRL, 32'h48);
        wait_for(2, 32'h1, "crystal_off");
        wr(`ADDR_POWER_MGMT_CTRL, 32'ha8);
        wait_for(0, 32'(DIV_64), "active_div");
        wr(`ADDR_TX_BUFFER_WRITE, 32'h1);
        wait_for(0, 32'(DIV_4), "active_div");
        chk("ring_active_flag", 32'h1, 32'(ring_active_flag));
        rd(`ADDR_POWER_MGMT_CTRL, 32'h68, "ctrl");
        wr(`ADDR_EXT_IRQ_FLAGS, 32'h08);
        repeat (100) @(negedge pclk);
        chk("ring_active_flag", 32'h1, 32'(ring_active_flag));
        @(posedge pclk);
        wr(`ADDR_POWER_MGMT_CTRL, 32'h40);
        rd(`ADDR_ACTIVITY_STATUS, 32'h00, "status");
        for (n = 0; n < 200; n++)
        begin
            apb(1'b0, `ADDR_ACTIVITY_STATUS, 32'h0, r, e);
            if (r[4] === 1'b1)
                break;
        end
        if (n == 200)
            tmo("crystal_ready_flag");
        wr(`ADDR_EXT_IRQ_FLAGS, 32'h08);
        wait_for(1, 32'h0, "ring_active_flag");
        finish_test();
    end
endmodule
